// file: hw/burst_sram_pkg.sv
package burst_sram_pkg;

	// word, lane and burst shape of the port
	localparam int DATA_W = 18;
	localparam int BYTE_W = 9;
	localparam int LANES = 2;
	localparam int BURST_LEN = 2;
	localparam int PAIR_W = DATA_W * BURST_LEN;
	localparam int PAIR_LANES = LANES * BURST_LEN;
	localparam int WORD1_LSB = DATA_W;

	// array size of the behavioural core
	localparam int ADDR_W = 4;
	localparam int DEPTH = 16;

	// power-up window in which the termination range is caught
	localparam int CLK_PERIOD_NS = 10;
	localparam int INIT_TIME_NS = 100;
	localparam int INIT_CYCLES_INT =
		(INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CNT_W = 5;
	localparam logic [INIT_CNT_W-1:0] INIT_LAST =
		INIT_CNT_W'(INIT_CYCLES_INT - 1);

	// write burst progress
	typedef enum logic [1:0] {WR_IDLE, WR_LOW, WR_HIGH} wr_e;

	// every pin sampled from the controller side
	typedef struct packed {
		logic k;
		logic kn;
		logic loadStrobeN;
		logic readWrite;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic [LANES-1:0] byteWriteSelN;
		logic termSel;
		logic termFloat;
	} pins_s;

	// reset values
	localparam pins_s PINS_RST = '{k: 1'b0, kn: 1'b0,
		loadStrobeN: 1'b1, readWrite: 1'b1, addr: '0, dq: '0,
		byteWriteSelN: '1, termSel: 1'b1, termFloat: 1'b0};
	localparam logic ECHO_RST = 1'b0;
	localparam logic TERM_HIGH_RST = 1'b1;

endpackage

// file: hw/burst_sram_mem.sv
`timescale 1ns/10ps
`default_nettype none

module burst_sram_mem (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// write port, one enable per byte lane of the word pair
	input wire logic wrEn,
	input wire logic [burst_sram_pkg::ADDR_W-1:0] wrAddr,
	input wire logic [burst_sram_pkg::PAIR_W-1:0] wrData,
	input wire logic [burst_sram_pkg::PAIR_LANES-1:0] wrByteEn,
	// read port, data registered
	input wire logic rdEn,
	input wire logic [burst_sram_pkg::ADDR_W-1:0] rdAddr,
	output logic [burst_sram_pkg::PAIR_W-1:0] rdData
);

	genvar lane;
	generate
		for (lane = 0; lane < burst_sram_pkg::PAIR_LANES; lane++) begin : g_lane
			logic [burst_sram_pkg::BYTE_W-1:0] bank [burst_sram_pkg::DEPTH];

			// a lane of its own keeps each byte single-driven; no reset on storage
			always_ff @(posedge clk) begin
				if (wrEn && wrByteEn[lane]) begin
					bank[wrAddr] <= wrData[lane*burst_sram_pkg::BYTE_W +:
						burst_sram_pkg::BYTE_W];
				end
			end

			// read during a write to the same word returns the old contents
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					rdData[lane*burst_sram_pkg::BYTE_W +:
						burst_sram_pkg::BYTE_W] <= '0;
				end else if (rdEn) begin
					rdData[lane*burst_sram_pkg::BYTE_W +:
						burst_sram_pkg::BYTE_W] <= bank[rdAddr];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// file: hw/burst_sram_port_control.sv
// Contract
// - low load strobe: select high reads, low writes
// - valid indicator marks cycles of driven read data
// - valid indicator changes on echo clock edges
// - accesses start on positive input clock rise
// - capture inputs and launch first word on K
// - capture and launch second word on negative clock; writes capture word0 there and word1 on K
// - free-running echo pair follows the input clocks
// - termination on only during writes, off for reads
// - termination range caught once at power-up
// - floating range select gives the high range
// - termination only on data, byte selects, clocks
// - load defines cycle; every burst is two words
// - data both edges; bus released when not reading
// - active-low byte selects mask bytes per word
`timescale 1ns/10ps
`default_nettype none

module burst_sram_port_control (
	// system clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// input clock pair from the controller
	input wire logic kPin,
	input wire logic kNegPin,
	// command pins
	input wire logic loadStrobeN,
	input wire logic readWriteSel,
	input wire logic [burst_sram_pkg::ADDR_W-1:0] addrPin,
	// data bus, split into its three signals
	input wire logic [burst_sram_pkg::DATA_W-1:0] dqIn,
	output logic [burst_sram_pkg::DATA_W-1:0] dqOut,
	output logic dqOe,
	input wire logic [burst_sram_pkg::LANES-1:0] byteWriteSelN,
	// echo clocks and valid indicator
	output logic echoClockPos,
	output logic echoClockNeg,
	output logic outputValid,
	// termination range select and per-group enables
	input wire logic termRangeSelect,
	input wire logic termRangeFloat,
	output logic termRangeHigh,
	output logic termDataEn,
	output logic termBwsEn,
	output logic termClkEn
);

	burst_sram_pkg::pins_s pinNow, pinMeta, pinSync;
	logic kRise, knRise, loadActive;
	logic next_echoClockPos, next_echoClockNeg;
	burst_sram_pkg::wr_e wrState, next_wrState;
	logic [burst_sram_pkg::ADDR_W-1:0] wrAddr, next_wrAddr;
	logic [burst_sram_pkg::DATA_W-1:0] wrLow, next_wrLow, next_dqOut;
	logic [burst_sram_pkg::LANES-1:0] wrLowEn, next_wrLowEn;
	logic termEn, next_termEn, memWrEn, memRdEn;
	logic [burst_sram_pkg::PAIR_W-1:0] memWrData, memRdData;
	logic [burst_sram_pkg::PAIR_LANES-1:0] memByteEn;
	logic rdPending, next_rdPending, secondPending, next_secondPending;
	logic [burst_sram_pkg::DATA_W-1:0] secondWord, next_secondWord;
	logic next_dqOe, next_outputValid;
	logic [burst_sram_pkg::INIT_CNT_W-1:0] initCount, next_initCount;
	logic rangeLatched, next_rangeLatched, next_termRangeHigh;

	// byte select active low, so enable is its inverse
	function automatic logic [burst_sram_pkg::LANES-1:0] laneEnable(
		input logic [burst_sram_pkg::LANES-1:0] selN);
		laneEnable = ~selN;
	endfunction

	// every pin is foreign to ref_clk, including the clock pair
	assign pinNow = {kPin, kNegPin, loadStrobeN, readWriteSel, addrPin,
		dqIn, byteWriteSelN, termRangeSelect, termRangeFloat};

	// two-flop synchroniser; all pins are delayed alike, so K keeps its data
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pinMeta <= burst_sram_pkg::PINS_RST;
			pinSync <= burst_sram_pkg::PINS_RST;
		end else begin
			pinMeta <= pinNow;
			pinSync <= pinMeta;
		end
	end

	// edges found against the echo registers, which hold the last sample
	assign kRise = pinSync.k && !echoClockPos;
	assign knRise = pinSync.kn && !echoClockNeg;
	assign loadActive = kRise && !pinSync.loadStrobeN;

	// echo pair runs whether or not an access is open
	always_comb begin
		next_echoClockPos = pinSync.k;
		next_echoClockNeg = pinSync.kn;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			echoClockPos <= burst_sram_pkg::ECHO_RST;
			echoClockNeg <= burst_sram_pkg::ECHO_RST;
		end else begin
			echoClockPos <= next_echoClockPos;
			echoClockNeg <= next_echoClockNeg;
		end
	end

	// write burst: word0 on the next negative rise, word1 on the next K rise
	always_comb begin
		next_wrState = wrState;
		next_wrAddr = wrAddr;
		next_wrLow = wrLow;
		next_wrLowEn = wrLowEn;
		unique case (wrState)
			burst_sram_pkg::WR_IDLE: next_wrState = burst_sram_pkg::WR_IDLE;
			burst_sram_pkg::WR_LOW: begin
				if (knRise) begin
					next_wrState = burst_sram_pkg::WR_HIGH;
					next_wrLow = pinSync.dq;
					next_wrLowEn = laneEnable(pinSync.byteWriteSelN);
				end
			end
			burst_sram_pkg::WR_HIGH: begin
				if (kRise) begin
					next_wrState = burst_sram_pkg::WR_IDLE;
				end
			end
		endcase
		// a new load may share the edge that closes the previous burst
		if (loadActive && !pinSync.readWrite &&
				wrState != burst_sram_pkg::WR_LOW) begin
			next_wrState = burst_sram_pkg::WR_LOW;
			next_wrAddr = pinSync.addr;
		end
		next_termEn = next_wrState != burst_sram_pkg::WR_IDLE;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wrState <= burst_sram_pkg::WR_IDLE;
			wrAddr <= '0;
			wrLow <= '0;
			wrLowEn <= '0;
			termEn <= 1'b0;
		end else begin
			wrState <= next_wrState;
			wrAddr <= next_wrAddr;
			wrLow <= next_wrLow;
			wrLowEn <= next_wrLowEn;
			termEn <= next_termEn;
		end
	end

	// the pair is written whole; masked bytes keep their stored value
	assign memWrEn = kRise && wrState == burst_sram_pkg::WR_HIGH;
	assign memWrData = {pinSync.dq, wrLow};
	assign memByteEn = {laneEnable(pinSync.byteWriteSelN), wrLowEn};
	assign memRdEn = loadActive && pinSync.readWrite;

	// termination follows write progress, on the switched groups only
	assign termDataEn = termEn;
	assign termBwsEn = termEn;
	assign termClkEn = termEn;

	burst_sram_mem u_mem (
		.clk(ref_clk),
		.rst(rst),
		.wrEn(memWrEn),
		.wrAddr(wrAddr),
		.wrData(memWrData),
		.wrByteEn(memByteEn),
		.rdEn(memRdEn),
		.rdAddr(pinSync.addr),
		.rdData(memRdData)
	);

	// read launch: word0 on the K rise after the load, word1 on the next
	// negative rise; word1 is held since a back-to-back read reloads memRdData
	always_comb begin
		next_rdPending = rdPending;
		next_secondPending = secondPending;
		next_secondWord = secondWord;
		next_dqOut = dqOut;
		next_dqOe = dqOe;
		next_outputValid = outputValid;
		if (kRise) begin
			next_rdPending = memRdEn;
			next_secondPending = rdPending;
			next_dqOe = rdPending;
			next_outputValid = rdPending;
			if (rdPending) begin
				next_dqOut = memRdData[burst_sram_pkg::DATA_W-1:0];
				next_secondWord = memRdData[burst_sram_pkg::WORD1_LSB +:
					burst_sram_pkg::DATA_W];
			end
		end else if (knRise) begin
			next_secondPending = 1'b0;
			next_dqOe = secondPending;
			next_outputValid = secondPending;
			if (secondPending) begin
				next_dqOut = secondWord;
			end
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdPending <= 1'b0;
			secondPending <= 1'b0;
			secondWord <= '0;
			dqOut <= '0;
			dqOe <= 1'b0;
			outputValid <= 1'b0;
		end else begin
			rdPending <= next_rdPending;
			secondPending <= next_secondPending;
			secondWord <= next_secondWord;
			dqOut <= next_dqOut;
			dqOe <= next_dqOe;
			outputValid <= next_outputValid;
		end
	end

	// range caught once after reset; later changes on the pin are ignored
	always_comb begin
		next_initCount = initCount;
		next_rangeLatched = rangeLatched;
		next_termRangeHigh = termRangeHigh;
		if (!rangeLatched) begin
			if (initCount == burst_sram_pkg::INIT_LAST) begin
				next_rangeLatched = 1'b1;
				next_termRangeHigh = pinSync.termFloat || pinSync.termSel;
			end else begin
				next_initCount = initCount + 1'b1;
			end
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			initCount <= '0;
			rangeLatched <= 1'b0;
			termRangeHigh <= burst_sram_pkg::TERM_HIGH_RST;
		end else begin
			initCount <= next_initCount;
			rangeLatched <= next_rangeLatched;
			termRangeHigh <= next_termRangeHigh;
		end
	end

	// checks; a K period of 125 ns is about 13 system cycles
	localparam int KWAIT = 40;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	property p_read_valid;
		memRdEn |-> ##[1:KWAIT] (outputValid && dqOe);
	endproperty
	a_read_valid: assert property (p_read_valid)
		else $error("read load not followed by valid data");

	property p_valid_edge;
		$changed(outputValid) |-> $changed(echoClockPos) ||
			$changed(echoClockNeg);
	endproperty
	a_valid_edge: assert property (p_valid_edge)
		else $error("valid changed away from an echo edge");

	property p_first_on_k;
		$rose(dqOe) |-> $rose(echoClockPos);
	endproperty
	a_first_on_k: assert property (p_first_on_k)
		else $error("read data launched off a K rise");

	property p_second_word;
		knRise && secondPending |=> outputValid &&
			dqOut == $past(secondWord);
	endproperty
	a_second_word: assert property (p_second_word)
		else $error("second read word missing on negative clock");

	property p_echo_follow;
		$changed(pinSync.k) |=> $changed(echoClockPos);
	endproperty
	a_echo_follow: assert property (p_echo_follow)
		else $error("echo clock did not follow input clock");

	property p_term_write;
		loadActive && !pinSync.readWrite |=> termDataEn;
	endproperty
	a_term_write: assert property (p_term_write)
		else $error("termination off during a write");

	property p_term_read;
		loadActive && pinSync.readWrite && wrState ==
			burst_sram_pkg::WR_IDLE |=> !termDataEn;
	endproperty
	a_term_read: assert property (p_term_read)
		else $error("termination on during a read");

	property p_range_frozen;
		rangeLatched && $past(rangeLatched) |-> $stable(termRangeHigh);
	endproperty
	a_range_frozen: assert property (p_range_frozen)
		else $error("termination range changed after power-up");

	property p_range_float;
		$rose(rangeLatched) |-> termRangeHigh ==
			($past(pinSync.termFloat) || $past(pinSync.termSel));
	endproperty
	a_range_float: assert property (p_range_float)
		else $error("termination range caught wrongly");

	property p_term_groups;
		termClkEn == termDataEn && termBwsEn == termDataEn;
	endproperty
	a_term_groups: assert property (p_term_groups)
		else $error("termination groups disagree");

	property p_burst_two;
		$rose(termEn) |-> ##[1:KWAIT] memWrEn ##1
			(termEn == $past(loadActive && !pinSync.readWrite));
	endproperty
	a_burst_two: assert property (p_burst_two)
		else $error("write burst did not complete");

	property p_bus_release;
		kRise && !rdPending |=> !dqOe && !outputValid;
	endproperty
	a_bus_release: assert property (p_bus_release)
		else $error("data bus driven with no valid read");

	c_read: cover property (memRdEn ##[1:KWAIT] $fell(outputValid));
	c_write: cover property ($rose(termEn) ##[1:KWAIT] memWrEn);
	c_back_read: cover property (kRise && rdPending && memRdEn);
	c_write_then_load: cover property (memWrEn && loadActive);

endmodule

`default_nettype wire

// file: bench/sram_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

module sram_ctrl_model (
	// observation clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// clocks and commands toward the port
	output var logic kPin,
	output logic kNegPin,
	output var logic loadStrobeN,
	output var logic readWriteSel,
	output var logic [burst_sram_pkg::ADDR_W-1:0] addrPin,
	output var logic [burst_sram_pkg::DATA_W-1:0] ctrlDq,
	output var logic [burst_sram_pkg::LANES-1:0] byteWriteSelN,
	// answers from the port
	input wire logic [burst_sram_pkg::DATA_W-1:0] dqOut,
	input wire logic dqOe,
	input wire logic echoClockPos,
	input wire logic echoClockNeg,
	input wire logic outputValid
);
	logic [burst_sram_pkg::DATA_W-1:0] rdQ[$];
	int badValid;
	int badAlign;
	logic prevPos;
	logic prevNeg;
	logic prevValid;

	// free-running input clock; 3 ns offset keeps its edges off ref_clk edges
	initial begin
		kPin = 1'b0;
		loadStrobeN = 1'b1;
		readWriteSel = 1'b1;
		addrPin = '0;
		ctrlDq = '0;
		byteWriteSelN = '1;
		badValid = 0;
		badAlign = 0;
		#3;
		forever #62.5 kPin = ~kPin;
	end
	assign kNegPin = ~kPin;

	// one K period of traffic; pins move a quarter period after K edges
	// so they hold on both sides of every sampling edge
	task automatic op(input logic rd,
			input logic [burst_sram_pkg::ADDR_W-1:0] a,
			input logic [burst_sram_pkg::DATA_W-1:0] w0, w1,
			input logic [burst_sram_pkg::LANES-1:0] b0, b1);
		loadStrobeN <= 1'b0;
		readWriteSel <= rd;
		addrPin <= a;
		@(posedge kPin);
		#31;
		ctrlDq <= rd ? ~ctrlDq : w0;
		byteWriteSelN <= rd ? '1 : b0;
		@(negedge kPin);
		#31;
		ctrlDq <= rd ? ~ctrlDq : w1;
		byteWriteSelN <= rd ? '1 : b1;
	endtask

	// released bus keeps changing so stale data never looks valid
	task automatic idle();
		loadStrobeN <= 1'b1;
		readWriteSel <= 1'b1;
		@(posedge kPin);
		#31;
		ctrlDq <= ~ctrlDq;
		byteWriteSelN <= '1;
		@(negedge kPin);
		#31;
		ctrlDq <= ~ctrlDq;
	endtask

	// take read words on echo rises only while valid; watch valid alignment
	always @(negedge ref_clk) begin
		if (!rst) begin
			if (echoClockPos && !prevPos && outputValid) begin
				rdQ.push_back(dqOut);
			end
			if (echoClockNeg && !prevNeg && outputValid) begin
				rdQ.push_back(dqOut);
			end
			if (outputValid !== dqOe) begin
				badValid++;
			end
			if (outputValid !== prevValid && !(echoClockPos && !prevPos)) begin
				badAlign++;
			end
		end
		prevPos = echoClockPos;
		prevNeg = echoClockNeg;
		prevValid = outputValid;
	end
endmodule

`default_nettype wire

// file: bench/burst_sram_port_control_bench.sv
`timescale 1ns/10ps
`default_nettype none

module burst_sram_port_control_bench;
	typedef struct packed {
		logic rd;
		logic [burst_sram_pkg::ADDR_W-1:0] addr;
		logic [burst_sram_pkg::DATA_W-1:0] w0;
		logic [burst_sram_pkg::DATA_W-1:0] w1;
		logic [burst_sram_pkg::LANES-1:0] b0;
		logic [burst_sram_pkg::LANES-1:0] b1;
	} row_s;

	logic ref_clk, rst, termRangeSelect, termRangeFloat;
	logic kPin, kNegPin, loadStrobeN, readWriteSel;
	logic [burst_sram_pkg::ADDR_W-1:0] addrPin;
	logic [burst_sram_pkg::DATA_W-1:0] ctrlDq, dqWire, dqOut;
	logic [burst_sram_pkg::LANES-1:0] byteWriteSelN;
	logic dqOe, echoClockPos, echoClockNeg, outputValid, termRangeHigh;
	logic termDataEn, termBwsEn, termClkEn, prevPos, prevNeg;
	logic [2:0] termAll;
	logic [burst_sram_pkg::DATA_W-1:0] shadow[burst_sram_pkg::DEPTH][2];
	logic [burst_sram_pkg::DATA_W-1:0] expQ[$];
	int n_mismatch, tests_run, risePos, riseNeg;

	// writes stream back to back, with masked lanes; reads follow
	row_s rows[10] = '{
		'{1'b0, 4'h0, 18'h1A5C3, 18'h2B4D6, 2'h0, 2'h0},
		'{1'b0, 4'hF, 18'h3FFFF, 18'h00001, 2'h0, 2'h0},
		'{1'b0, 4'h5, 18'h0ABCD, 18'h15432, 2'h0, 2'h0},
		'{1'b0, 4'h5, 18'h3FFFF, 18'h3FFFF, 2'h1, 2'h2},
		'{1'b1, 4'h0, 18'h00000, 18'h00000, 2'h3, 2'h3},
		'{1'b1, 4'hF, 18'h00000, 18'h00000, 2'h3, 2'h3},
		'{1'b1, 4'h5, 18'h00000, 18'h00000, 2'h3, 2'h3},
		'{1'b0, 4'h0, 18'h00000, 18'h3FFFF, 2'h3, 2'h3},
		'{1'b1, 4'hF, 18'h00000, 18'h00000, 2'h3, 2'h3},
		'{1'b1, 4'h0, 18'h00000, 18'h00000, 2'h3, 2'h3}};

	// the shared data wire: the port wins while it drives
	assign dqWire = dqOe ? dqOut : ctrlDq;
	assign termAll = {termDataEn, termBwsEn, termClkEn};

	always #5 ref_clk = ~ref_clk;

	sram_ctrl_model ctrl_u (.ref_clk(ref_clk), .rst(rst), .kPin(kPin),
		.kNegPin(kNegPin), .loadStrobeN(loadStrobeN),
		.readWriteSel(readWriteSel), .addrPin(addrPin), .ctrlDq(ctrlDq),
		.byteWriteSelN(byteWriteSelN), .dqOut(dqOut), .dqOe(dqOe),
		.echoClockPos(echoClockPos), .echoClockNeg(echoClockNeg),
		.outputValid(outputValid));

	burst_sram_port_control dut_u (.ref_clk(ref_clk), .rst(rst),
		.kPin(kPin), .kNegPin(kNegPin), .loadStrobeN(loadStrobeN),
		.readWriteSel(readWriteSel), .addrPin(addrPin), .dqIn(dqWire),
		.dqOut(dqOut), .dqOe(dqOe), .byteWriteSelN(byteWriteSelN),
		.echoClockPos(echoClockPos), .echoClockNeg(echoClockNeg),
		.outputValid(outputValid), .termRangeSelect(termRangeSelect),
		.termRangeFloat(termRangeFloat), .termRangeHigh(termRangeHigh),
		.termDataEn(termDataEn), .termBwsEn(termBwsEn),
		.termClkEn(termClkEn));

	// a deselected lane keeps the stored byte
	function automatic logic [burst_sram_pkg::DATA_W-1:0] merge(
			input logic [burst_sram_pkg::DATA_W-1:0] old, nw,
			input logic [burst_sram_pkg::LANES-1:0] selN);
		merge = old;
		for (int l = 0; l < burst_sram_pkg::LANES; l++) begin
			if (!selN[l]) begin
				merge[l*burst_sram_pkg::BYTE_W +: burst_sram_pkg::BYTE_W] =
					nw[l*burst_sram_pkg::BYTE_W +: burst_sram_pkg::BYTE_W];
			end
		end
	endfunction

	task automatic check(input logic [35:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// the whole run takes about 4 us; a hang is cut well after that
	initial begin
		#50000;
		n_mismatch++;
		$display("ERROR %0t: run did not finish", $time);
		print_verdict();
	end

	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		termRangeSelect = 1'b1;
		termRangeFloat = 1'b0;
		n_mismatch = 0;
		tests_run = 0;
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		// rows go out one K period each, read words are matched afterwards
		@(negedge kPin);
		#31;
		foreach (rows[i]) begin
			ctrl_u.op(rows[i].rd, rows[i].addr, rows[i].w0, rows[i].w1,
				rows[i].b0, rows[i].b1);
			check(36'(termAll), 36'(rows[i].rd ? 3'h0 : 3'h7));
			if (rows[i].rd) begin
				expQ.push_back(shadow[rows[i].addr][0]);
				expQ.push_back(shadow[rows[i].addr][1]);
			end else begin
				shadow[rows[i].addr][0] = merge(shadow[rows[i].addr][0],
					rows[i].w0, rows[i].b0);
				shadow[rows[i].addr][1] = merge(shadow[rows[i].addr][1],
					rows[i].w1, rows[i].b1);
			end
		end
		ctrl_u.idle();
		ctrl_u.idle();
		for (int n = 0; n < 100 && ctrl_u.rdQ.size() < 10; n++) begin
			@(negedge ref_clk);
		end
		check(36'(ctrl_u.rdQ.size()), 36'(expQ.size()));
		while (ctrl_u.rdQ.size() > 0 && expQ.size() > 0) begin
			check(36'(ctrl_u.rdQ.pop_front()), 36'(expQ.pop_front()));
		end
		check(36'({dqOe, outputValid}), 36'h0);
		check(36'(ctrl_u.badValid), 36'h0);
		check(36'(ctrl_u.badAlign), 36'h0);
		$display("burst rows test done");
		// idle echoes keep running: one rise of each per K period
		@(posedge kPin);
		prevPos = echoClockPos;
		prevNeg = echoClockNeg;
		risePos = 0;
		riseNeg = 0;
		repeat (100) begin
			@(negedge ref_clk);
			risePos += int'(echoClockPos && !prevPos);
			riseNeg += int'(echoClockNeg && !prevNeg);
			prevPos = echoClockPos;
			prevNeg = echoClockNeg;
		end
		check(36'(risePos), 36'h8);
		check(36'(riseNeg), 36'h8);
		$display("echo clock test done");
		// range select low, high, then floating, each from a fresh reset
		for (int c = 0; c < 3; c++) begin
			rst = 1'b1;
			termRangeSelect = 1'(c == 1);
			termRangeFloat = 1'(c == 2);
			repeat (5) @(negedge ref_clk);
			check(36'({dqOe, outputValid, echoClockPos, termAll}), 36'h0);
			check(36'(termRangeHigh), 36'h1);
			rst = 1'b0;
			repeat (20) @(negedge ref_clk);
			check(36'(termRangeHigh), 36'(c != 0));
		end
		// the range is latched; a later pin change must not move it
		termRangeFloat = 1'b0;
		repeat (20) @(negedge ref_clk);
		check(36'(termRangeHigh), 36'h1);
		$display("termination range test done");
		print_verdict();
	end
endmodule

`default_nettype wire
